//--- design/drm_pkg.sv
/*
  Types of the dual-port block RAM: clocking modes and the per-port pin group.
  Assumes drm_regs.svh is on the include path.
*/
package drm_pkg;
  `include "drm_regs.svh"

  typedef enum logic [2:0] {
    DRM_IND_TDP,
    DRM_IO_TDP,
    DRM_IO_SDP,
    DRM_RW_SDP,
    DRM_SINGLE
  } drm_mode_e;

  typedef struct packed {
    logic clk_in;
    logic ce_in;
    logic clr_in;
    logic clk_out;
    logic ce_out;
    logic clr_out;
    logic we;
    logic rden;
    logic be_valid;
    logic [`DRM_BE_W-1:0] be;
    logic [`DRM_AW-1:0] addr;
    logic [`DRM_DW-1:0] din;
  } drm_pin_s;
endpackage

//--- design/drm_ram.sv
/*
  Dual-port 8K x 72 block RAM with selectable clocking: independent, input/output,
  read/write and single-port. Port clocks, enables and clears arrive as fabric pins
  and are sampled on mclk; their rising edges act as the registers' active edges.
  Assumes port clocks are much slower than mclk (at least 4 mclk per level) and that
  the port pins are steady around each port clock edge.
*/
`include "drm_regs.svh"
module drm_ram
  import drm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // clocking mode
  input wire drm_mode_e mode,
  // port pin groups
  input wire drm_pin_s pin_a,
  input wire drm_pin_s pin_b,
  // read data
  output logic [`DRM_DW-1:0] dout_a,
  output logic [`DRM_DW-1:0] dout_b
);

  // output registers use their own clock only in input/output modes
  function automatic logic io_mode(input drm_mode_e m);
    return (m == DRM_IO_TDP) || (m == DRM_IO_SDP);
  endfunction

  function automatic logic sdp_mode(input drm_mode_e m);
    return (m == DRM_IO_SDP) || (m == DRM_RW_SDP);
  endfunction

  // single-port mode splits the array into two halves, one per port
  function automatic logic [`DRM_RAM_AW-1:0] ram_addr(input drm_mode_e m, input logic hi,
                                                      input logic [`DRM_AW-1:0] a);
    if (m == DRM_SINGLE) begin
      return {hi, a[`DRM_RAM_AW-2:0]};
    end
    return a[`DRM_RAM_AW-1:0];
  endfunction

  function automatic logic [`DRM_BE_W-1:0] be_mask(input logic valid,
                                                   input logic [`DRM_BE_W-1:0] be);
    return valid ? be : {`DRM_BE_W{1'b1}};
  endfunction

  logic [`DRM_DW-1:0] mem [`DRM_DEPTH];

  drm_mode_e mode_s1_q;
  drm_mode_e mode_q;
  drm_pin_s pin_w [`DRM_NPORT];
  drm_pin_s s1_q [`DRM_NPORT];
  drm_pin_s s2_q [`DRM_NPORT];
  logic ci_q [`DRM_NPORT];
  logic co_q [`DRM_NPORT];
  logic in_edge [`DRM_NPORT];
  logic o_edge [`DRM_NPORT];
  logic o_ce [`DRM_NPORT];
  logic o_clr [`DRM_NPORT];
  logic wr_op [`DRM_NPORT];
  logic rd_op [`DRM_NPORT];
  logic [`DRM_RAM_AW-1:0] ma [`DRM_NPORT];
  logic [`DRM_AW-1:0] addr_q [`DRM_NPORT];
  logic [`DRM_DW-1:0] din_q [`DRM_NPORT];
  logic [`DRM_BE_W-1:0] be_q [`DRM_NPORT];
  logic we_q [`DRM_NPORT];
  logic rden_q [`DRM_NPORT];
  logic pend_q [`DRM_NPORT];
  logic [`DRM_DW-1:0] raw_q [`DRM_NPORT];
  logic [`DRM_DW-1:0] dout_q [`DRM_NPORT];

  assign pin_w[0] = pin_a;
  assign pin_w[1] = pin_b;
  assign dout_a = dout_q[0];
  assign dout_b = dout_q[1];

  // mode is a static strap, still synchronised since it comes from the fabric
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_s1_q <= DRM_IND_TDP;
      mode_q <= DRM_IND_TDP;
    end else begin
      mode_s1_q <= mode;
      mode_q <= mode_s1_q;
    end
  end

  for (genvar p = 0; p < `DRM_NPORT; p++) begin : g_port
    // all pins pass two flops; skew across a wide bus is harmless while it is steady
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        s1_q[p] <= '0;
        s2_q[p] <= '0;
      end else begin
        s1_q[p] <= pin_w[p];
        s2_q[p] <= s1_q[p];
      end
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ci_q[p] <= `DRM_CLR_VAL;
        co_q[p] <= `DRM_CLR_VAL;
      end else begin
        ci_q[p] <= s2_q[p].clk_in;
        co_q[p] <= s2_q[p].clk_out;
      end
    end

    // each port owns its clock edge
    assign in_edge[p] = s2_q[p].clk_in & ~ci_q[p];
    // output register follows the second clock only in input/output modes
    assign o_edge[p] = io_mode(mode_q) ? (s2_q[p].clk_out & ~co_q[p]) : in_edge[p];
    assign o_ce[p] = io_mode(mode_q) ? s2_q[p].ce_out : s2_q[p].ce_in;
    assign o_clr[p] = io_mode(mode_q) ? s2_q[p].clr_out : s2_q[p].clr_in;
    // simple dual-port: port a writes, port b reads on rden; else we picks
    assign wr_op[p] = we_q[p] & (!sdp_mode(mode_q) || (p == 0));
    assign rd_op[p] = sdp_mode(mode_q) ? ((p == 1) && rden_q[p]) : !we_q[p];
    assign ma[p] = ram_addr(mode_q, 1'(p), addr_q[p]);

    // input registers: data, address, write enable, byte enables
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        addr_q[p] <= '0;
        din_q[p] <= '0;
        be_q[p] <= '0;
        we_q[p] <= `DRM_CLR_VAL;
        pend_q[p] <= `DRM_CLR_VAL;
      end else if (s2_q[p].clr_in) begin
        addr_q[p] <= '0;
        din_q[p] <= '0;
        be_q[p] <= '0;
        we_q[p] <= `DRM_CLR_VAL;
        pend_q[p] <= `DRM_CLR_VAL;
      end else begin
        pend_q[p] <= in_edge[p] & s2_q[p].ce_in;
        if (in_edge[p] && s2_q[p].ce_in) begin
          addr_q[p] <= s2_q[p].addr;
          din_q[p] <= s2_q[p].din;
          be_q[p] <= be_mask(s2_q[p].be_valid, s2_q[p].be);
          we_q[p] <= s2_q[p].we;
        end
      end
    end

    // read enable register; a clear leaves it alone in simple dual-port
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        rden_q[p] <= `DRM_CLR_VAL;
      end else if (s2_q[p].clr_in && !sdp_mode(mode_q)) begin
        rden_q[p] <= `DRM_CLR_VAL;
      end else if (in_edge[p] && s2_q[p].ce_in) begin
        rden_q[p] <= s2_q[p].rden;
      end
    end

    // array read one mclk after the input edge; no read on a same-port write, raw_q keeps its last word
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        raw_q[p] <= '0;
      end else if (pend_q[p] && rd_op[p]) begin
        raw_q[p] <= mem[ma[p]];
      end
    end

    // output register, so reads show one port output edge later than the access
    always_ff @(posedge mclk) begin
      if (!rst_n || o_clr[p]) begin
        dout_q[p] <= '0;
      end else if (o_edge[p] && o_ce[p]) begin
        dout_q[p] <= raw_q[p];
      end
    end
  end

  // byte-lane writes, any lane combination; port b wins a same-word collision
  always_ff @(posedge mclk) begin
    for (int p = 0; p < `DRM_NPORT; p++) begin
      for (int b = 0; b < `DRM_BE_W; b++) begin
        if (pend_q[p] && wr_op[p] && be_q[p][b]) begin
          mem[ma[p]][b*`DRM_BYTE_W +: `DRM_BYTE_W] <= din_q[p][b*`DRM_BYTE_W +: `DRM_BYTE_W];
        end
      end
    end
  end

  // helper state for the byte-lane check
  logic [`DRM_RAM_AW-1:0] chk_a_q;
  logic [`DRM_BYTE_W-1:0] chk_old_q;
  always_ff @(posedge mclk) begin
    chk_a_q <= ma[0];
    chk_old_q <= mem[ma[0]][`DRM_BYTE_W-1:0];
  end

  // whole word under port b, so a write attempt from the read side shows up
  logic [`DRM_RAM_AW-1:0] chk_b_a_q;
  logic [`DRM_DW-1:0] chk_b_old_q;
  always_ff @(posedge mclk) begin
    chk_b_a_q <= ma[1];
    chk_b_old_q <= mem[ma[1]];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_ce_hold;
    o_edge[0] && !o_ce[0] && !o_clr[0] |=> $stable(dout_a);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("dout changed with enable low");

  property p_clr_zero;
    o_clr[1] |=> dout_b == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear did not zero dout");

  property p_in_hold;
    in_edge[0] && !s2_q[0].ce_in && !s2_q[0].clr_in |=> $stable(addr_q[0]) && !pend_q[0];
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("input regs moved, enable low");

  property p_rden_noclr;
    sdp_mode(mode_q) && s2_q[1].clr_in && !in_edge[1] |=> $stable(rden_q[1]);
  endproperty
  a_rden_noclr: assert property (p_rden_noclr) else $error("rden was cleared");

  property p_io_out;
    io_mode(mode_q) && !(s2_q[0].clk_out && !co_q[0]) && !s2_q[0].clr_out
      |=> $stable(dout_a);
  endproperty
  a_io_out: assert property (p_io_out) else $error("output moved off output clock");

  property p_ind_clk;
    mode_q == DRM_IND_TDP && !in_edge[1] && !s2_q[1].clr_in |=> $stable(dout_b);
  endproperty
  a_ind_clk: assert property (p_ind_clk) else $error("port b moved off its clock");

  property p_byte_gate;
    pend_q[0] && wr_op[0] && !be_q[0][0] && !(pend_q[1] && wr_op[1])
      |=> mem[chk_a_q][`DRM_BYTE_W-1:0] == chk_old_q;
  endproperty
  a_byte_gate: assert property (p_byte_gate) else $error("disabled byte lane written");

  property p_be_default;
    in_edge[0] && s2_q[0].ce_in && !s2_q[0].clr_in && !s2_q[0].be_valid
      |=> be_q[0] == {`DRM_BE_W{1'b1}};
  endproperty
  a_be_default: assert property (p_be_default) else $error("byte enables not high");

  property p_sdp_nowrite;
    sdp_mode(mode_q) && pend_q[1] && we_q[1] && !(pend_q[0] && wr_op[0])
      |=> mem[chk_b_a_q] == chk_b_old_q;
  endproperty
  a_sdp_nowrite: assert property (p_sdp_nowrite) else $error("read side wrote");

  property p_ce_hold_b;
    o_edge[1] && !o_ce[1] && !o_clr[1] |=> $stable(dout_b);
  endproperty
  a_ce_hold_b: assert property (p_ce_hold_b) else $error("dout_b moved, ce low");

  property p_clr_zero_a;
    o_clr[0] |=> dout_a == '0;
  endproperty
  a_clr_zero_a: assert property (p_clr_zero_a) else $error("dout_a not cleared");

  property p_in_hold_b;
    in_edge[1] && !s2_q[1].ce_in && !s2_q[1].clr_in |=> $stable(addr_q[1]) && !pend_q[1];
  endproperty
  a_in_hold_b: assert property (p_in_hold_b) else $error("port b regs moved, ce low");

  property p_capture_a;
    in_edge[0] && s2_q[0].ce_in && !s2_q[0].clr_in
      |=> pend_q[0] && addr_q[0] == $past(s2_q[0].addr) && din_q[0] == $past(s2_q[0].din);
  endproperty
  a_capture_a: assert property (p_capture_a) else $error("port a not loaded");

  property p_capture_b;
    in_edge[1] && s2_q[1].ce_in && !s2_q[1].clr_in
      |=> pend_q[1] && we_q[1] == $past(s2_q[1].we) && rden_q[1] == $past(s2_q[1].rden);
  endproperty
  a_capture_b: assert property (p_capture_b) else $error("port b not loaded");

  property p_clr_in_a;
    s2_q[0].clr_in |=> addr_q[0] == '0 && din_q[0] == '0 && !we_q[0] && !pend_q[0];
  endproperty
  a_clr_in_a: assert property (p_clr_in_a) else $error("port a not cleared");

  property p_clr_in_b;
    s2_q[1].clr_in |=> addr_q[1] == '0 && din_q[1] == '0 && !we_q[1] && !pend_q[1];
  endproperty
  a_clr_in_b: assert property (p_clr_in_b) else $error("port b not cleared");

  property p_be_mask_a;
    in_edge[0] && s2_q[0].ce_in && !s2_q[0].clr_in && s2_q[0].be_valid
      |=> be_q[0] == $past(s2_q[0].be);
  endproperty
  a_be_mask_a: assert property (p_be_mask_a) else $error("byte enables not taken");

  property p_single_split;
    mode_q == DRM_SINGLE |-> !ma[0][`DRM_RAM_AW-1] && ma[1][`DRM_RAM_AW-1];
  endproperty
  a_single_split: assert property (p_single_split) else $error("halves overlap");

  property p_out_load_b;
    o_edge[1] && o_ce[1] && !o_clr[1] |=> dout_b == $past(raw_q[1]);
  endproperty
  a_out_load_b: assert property (p_out_load_b) else $error("dout_b not loaded");

  property p_rd_a_none;
    sdp_mode(mode_q) |=> $stable(raw_q[0]);
  endproperty
  a_rd_a_none: assert property (p_rd_a_none) else $error("write side read");

  property p_ind_clk_a;
    mode_q == DRM_IND_TDP && !in_edge[0] && !s2_q[0].clr_in |=> $stable(dout_a);
  endproperty
  a_ind_clk_a: assert property (p_ind_clk_a) else $error("port a moved off its clock");

  property p_rw_out;
    mode_q == DRM_RW_SDP && !in_edge[1] && !s2_q[1].clr_in |=> $stable(dout_b);
  endproperty
  a_rw_out: assert property (p_rw_out) else $error("read output off read clock");

  property p_io_out_b;
    io_mode(mode_q) && !(s2_q[1].clk_out && !co_q[1]) && !s2_q[1].clr_out
      |=> $stable(dout_b);
  endproperty
  a_io_out_b: assert property (p_io_out_b) else $error("dout_b off out clock");

  property p_clr_out_sep;
    io_mode(mode_q) && s2_q[1].clr_out && !s2_q[1].clr_in && !in_edge[1]
      |=> $stable(addr_q[1]) && $stable(din_q[1]);
  endproperty
  a_clr_out_sep: assert property (p_clr_out_sep) else $error("inputs cleared");

  property p_sp_hold_a;
    mode_q == DRM_SINGLE && !in_edge[0] && !s2_q[0].clr_in |=> $stable(dout_a);
  endproperty
  a_sp_hold_a: assert property (p_sp_hold_a) else $error("dout_a off port clock");

  c_write_a: cover property (pend_q[0] && wr_op[0]);
  c_read_b: cover property (pend_q[1] && rd_op[1] ##[1:40] o_edge[1] && o_ce[1]);
  c_io_mode: cover property (io_mode(mode_q) && o_edge[0] && o_ce[0]);
  c_single: cover property (mode_q == DRM_SINGLE && pend_q[0] && pend_q[1]);
  c_rw_read: cover property (mode_q == DRM_RW_SDP && pend_q[1] && rd_op[1]);

endmodule

//--- design/drm_regs.svh
/*
  Constants of the dual-port block RAM: port widths, byte lanes, array depth and reset values.
  Assumes it is included by the package and by the RAM module before use.
*/
// Functional notes
// - independent clock mode: one clock per port
// - each port's registers run on own clock
// - per-port clock enable and clear
// - input/output clocking in true and simple dual-port
// - input clock drives data, write enable, address
// - output clock drives only output registers
// - separate enables and clears, input and output
// - read/write clocking, simple dual-port, two clocks
// - write clock registers data, address, write enable
// - read clock registers read address, enable, output
// - each clock own enable; both sides clearable
// - simple dual-port: read enable never cleared
// - single-port mode for non-simultaneous access
// - two independent single-port memories per block
// - 16-bit address, 8 byte enables, write enable, clock
// - 72-bit write and read data buses
// - unused byte enables default all high
// - byte enable n gates bits 9n to 9n+8
`ifndef DRM_REGS_SVH
`define DRM_REGS_SVH
`define DRM_AW 16
`define DRM_DW 72
`define DRM_BE_W 8
`define DRM_BYTE_W 9
`define DRM_RAM_AW 13
`define DRM_DEPTH 8192
`define DRM_NPORT 2
`define DRM_CLR_VAL 1'b0
`endif

//--- verification/drm_fab_port.sv
/*
  Fabric-side model of one RAM port: slow port clocks, pins steady around each edge.
  Assumes mclk samples the pins; clock highs last 6 mclk, lows at least 10, pins set 4 mclk before a rise.
*/
module drm_fab_port
  import drm_pkg::*;
(
  // sampling clock
  input wire logic mclk,
  // port pins
  output drm_pin_s pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = '0;
  // one input clock edge; rden held high, so we picks write or read outside simple dual-port
  task automatic acc(input logic we, input logic ce, input logic bv,
    input logic [7:0] be, input logic [15:0] a, input logic [71:0] d);
    @(posedge mclk);
    pin.we <= we;
    pin.rden <= 1'b1;
    pin.ce_in <= ce;
    pin.be_valid <= bv;
    pin.be <= be;
    pin.addr <= a;
    pin.din <= d;
    repeat (4) @(posedge mclk);
    pin.clk_in <= 1'b1;
    repeat (6) @(posedge mclk);
    pin.clk_in <= 1'b0;
    repeat (5) @(posedge mclk);
    // released lines show junk, so a stale word cannot pass
    pin.din <= ~d;
    pin.addr <= ~a;
  endtask
  // one output clock edge, used by the input/output modes
  task automatic oclk();
    @(posedge mclk);
    pin.ce_out <= 1'b1;
    repeat (4) @(posedge mclk);
    pin.clk_out <= 1'b1;
    repeat (6) @(posedge mclk);
    pin.clk_out <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  task automatic clr(input logic ci, input logic co);
    @(posedge mclk);
    pin.clr_in <= ci;
    pin.clr_out <= co;
    repeat (5) @(posedge mclk);
  endtask
endmodule

//--- verification/test_dual_port_ram_clock_modes.sv
/*
  Self-checking bench of the dual-port RAM: each clocking mode, byte lanes, enables, clears.
  Assumes drm_pkg and drm_fab_port are compiled first.
*/
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module test_dual_port_ram_clock_modes
  import drm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [71:0] D1 = 72'h123456789ABCDEF012;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  drm_mode_e mode = DRM_IND_TDP;
  drm_pin_s pin_a;
  drm_pin_s pin_b;
  logic [71:0] dout_a;
  logic [71:0] dout_b;
  int err_count = 0;
  int total_checks = 0;
  always #50 mclk = ~mclk;
  drm_ram dut_u (.mclk(mclk), .rst_n(rst_n), .mode(mode), .pin_a(pin_a), .pin_b(pin_b),
    .dout_a(dout_a), .dout_b(dout_b));
  drm_fab_port fab_a (.mclk(mclk), .pin(pin_a));
  drm_fab_port fab_b (.mclk(mclk), .pin(pin_b));
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic set_mode(input drm_mode_e m);
    @(posedge mclk);
    mode <= m;
    repeat (4) @(posedge mclk);
  endtask
  // second edge moves the fetched word to the output register
  task automatic rd_a(input logic [15:0] a);
    fab_a.acc(1'b0, 1'b1, 1'b0, 8'h00, a, 72'h0);
    fab_a.acc(1'b0, 1'b1, 1'b0, 8'h00, a, 72'h0);
  endtask
  task automatic rd_b(input logic [15:0] a);
    fab_b.acc(1'b0, 1'b1, 1'b0, 8'h00, a, 72'h0);
    fab_b.acc(1'b0, 1'b1, 1'b0, 8'h00, a, 72'h0);
  endtask
  task automatic t_ind();
    set_mode(DRM_IND_TDP);
    fab_a.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0010, D1);
    rd_b(16'h0010);
    `CHK("ind dout_b", D1, dout_b)
  endtask
  task automatic t_be();
    fab_a.acc(1'b1, 1'b1, 1'b1, 8'h81, 16'h0010, 72'h0);
    fab_a.acc(1'b1, 1'b1, 1'b1, 8'h7E, 16'h0010, D1);
    rd_b(16'h0010);
    `CHK("lanes dout_b", {9'h000, D1[62:9], 9'h000}, dout_b)
  endtask
  task automatic t_ce();
    fab_a.acc(1'b1, 1'b0, 1'b0, 8'h00, 16'h0010, ~D1);
    rd_b(16'h0010);
    `CHK("ce dout_b", {9'h000, D1[62:9], 9'h000}, dout_b)
  endtask
  task automatic t_clr();
    rd_a(16'h0010);
    fab_b.clr(1'b1, 1'b0);
    `CHK("clr dout_b", 72'h0, dout_b)
    `CHK("clr dout_a", {9'h000, D1[62:9], 9'h000}, dout_a)
    fab_b.clr(1'b0, 1'b0);
  endtask
  task automatic t_rw();
    set_mode(DRM_RW_SDP);
    fab_a.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0020, ~D1);
    rd_b(16'h0020);
    `CHK("rw dout_b", ~D1, dout_b)
    fab_b.clr(1'b1, 1'b0);
    `CHK("rw clr", 72'h0, dout_b)
    fab_b.clr(1'b0, 1'b0);
    fab_b.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0020, D1);
    rd_b(16'h0020);
    `CHK("rw no b write", ~D1, dout_b)
  endtask
  task automatic t_io();
    drm_mode_e ml[2] = '{DRM_IO_TDP, DRM_IO_SDP};
    logic [71:0] prev;
    prev = ~D1;
    foreach (ml[i]) begin
      set_mode(ml[i]);
      fab_a.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0030, D1 + i);
      fab_b.acc(1'b0, 1'b1, 1'b0, 8'h00, 16'h0030, 72'h0);
      `CHK("io hold", prev, dout_b)
      fab_b.oclk();
      `CHK("io dout_b", D1 + i, dout_b)
      fab_b.clr(1'b1, 1'b0);
      `CHK("io in clr", D1 + i, dout_b)
      fab_b.clr(1'b0, 1'b1);
      `CHK("io clr", 72'h0, dout_b)
      fab_b.clr(1'b0, 1'b0);
      prev = 72'h0;
    end
  endtask
  task automatic t_single();
    set_mode(DRM_SINGLE);
    fab_a.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0005, D1);
    fab_b.acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0005, ~D1);
    rd_a(16'h0005);
    rd_b(16'h0005);
    `CHK("single a", D1, dout_a)
    `CHK("single b", ~D1, dout_b)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_ind();
    t_be();
    t_ce();
    t_clr();
    t_rw();
    t_io();
    t_single();
    conclude();
  end
  // the run needs under 1500 mclk; allow far more before giving up
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule
